// ==== core/uarx_rx_recovery.sv ====
/*
 * uarx_rx_recovery: start detection, bit timing realignment and majority
 * vote recovery of an asynchronous receive line.
 * assumes the buffer side accepts o_frame_valid at any time (no back-pressure).
 */
//
// Overview of operation
// - oversample at 16x baud, or 8x when double speed is selected.
// - idle-high to low starts detection; the first low sample is sample one.
// - qualify start on samples 8,9,10 normal or 4,5,6 double speed.
// - two or more high qualifying samples reject start; watch for next edge.
// - valid start realigns bit timing, anew for every frame.
// - per-bit state counter of 16 or 8 states numbers each sample.
// - bit value is majority of three centre samples.
// - recover data and parity bits through first stop bit only.
// - stop bit majority voted; zero sets frame error.
// - accept new falling edge right after last stop voting sample.
// - support five to ten data plus parity bits.
// - baud mismatch split equally; receiver error within recommended percent.
// - frame error travels with its frame; stop count setting ignored.
`timescale 1ns/1ps
module uarx_rx_recovery
   import uarx_pkg::*;
(
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   // serial line and configuration
   input  wire logic        i_rx_line,
   input  wire uarx_cfg_s   i_cfg,
   // recovered frame
   output uarx_frame_s      o_frame,
   output logic            o_frame_valid,
   output logic            o_busy
);
   // ==========================================================
   // synchronizer and sample strobe
   logic [1:0]  sync_ff;
   logic        tick;
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         sync_ff <= SYNC_IDLE;
      else
         sync_ff <= {sync_ff[0], i_rx_line};
   end
   wire line = sync_ff[1];

   uarx_tick_gen u_tick (
      .i_clock        (i_clock),
      .i_rst          (i_rst),
      .i_baud_divisor (i_cfg.baud_divisor),
      .o_tick         (tick)
   );

   // ==========================================================
   // state
   uarx_state_e state_ff, nxt_state;
   logic [3:0]  phase_ff, nxt_phase;
   logic [1:0]  ones_ff, nxt_ones;
   logic [3:0]  nbit_ff, nxt_nbit;
   logic [9:0]  data_ff, nxt_data;
   logic        prev_ff;
   uarx_frame_s frame_ff;
   logic        valid_ff;

   wire         dbl      = i_cfg.double_speed_select;
   wire [3:0]   last_st  = dbl ? LAST_DBL : LAST_NORM;
   wire [3:0]   st_a     = dbl ? START_A_DBL : START_A_NORM;
   wire [3:0]   st_c     = dbl ? START_C_DBL : START_C_NORM;
   wire [3:0]   md_a     = dbl ? MID_A_DBL : MID_A_NORM;
   wire [3:0]   md_c     = dbl ? MID_C_DBL : MID_C_NORM;
   // out of range lengths are clamped so timing covers 5..10 bits
   wire [3:0]   nbits    = (i_cfg.frame_bits < MIN_BITS) ? MIN_BITS :
                           (i_cfg.frame_bits > MAX_BITS) ? MAX_BITS : i_cfg.frame_bits;
   // phase holds the sample number of the previous tick; sample 16 reads as 0
   wire [4:0]   cur_sum  = {1'b0, phase_ff} + {1'b0, STATE_ONE};
   wire [3:0]   cur      = cur_sum[3:0];
   wire         in_win_s = (cur >= st_a) && (cur <= st_c);
   wire         in_win_d = (cur >= md_a) && (cur <= md_c);
   wire [1:0]   ones_inc = ones_ff + {1'b0, line};
   wire         vote_win = (ones_inc >= 2'h2);
   wire         fall     = prev_ff && !line;
   // one past the last sample of a bit, in the same 4-bit phase arithmetic
   wire [4:0]   wrap_sum = {1'b0, last_st} + {1'b0, STATE_ONE};
   wire [3:0]   bit_wrap = wrap_sum[3:0];

   always_comb
   begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_ones  = ones_ff;
      nxt_nbit  = nbit_ff;
      nxt_data  = data_ff;
      if (tick)
      begin
         case (state_ff)
            UARX_IDLE:
            begin
               if (fall)
               begin
                  nxt_state = UARX_START;
                  nxt_phase = STATE_ONE;
                  nxt_ones  = 2'h0;
               end
            end
            UARX_START:
            begin
               nxt_phase = cur;
               if (in_win_s)
                  nxt_ones = ones_inc;
               if (cur == st_c)
               begin
                  if (vote_win)
                     nxt_state = UARX_IDLE;
                  else
                  begin
                     nxt_state = UARX_DATA;
                     nxt_nbit  = 4'h0;
                     nxt_ones  = 2'h0;
                     nxt_data  = DATA_ZERO;
                  end
               end
            end
            UARX_DATA, UARX_STOP:
            begin
               // start vote and bit votes end on the same sample number, so the
               // numbering runs on from the start bit and wraps once per bit
               nxt_phase = (cur == bit_wrap) ? STATE_ZERO : cur;
               if (in_win_d)
                  nxt_ones = ones_inc;
               if (cur == md_c)
               begin
                  nxt_ones  = 2'h0;
                  if (state_ff == UARX_DATA)
                  begin
                     nxt_data[nbit_ff] = vote_win;
                     nxt_nbit          = nbit_ff + 4'h1;
                     if (nbit_ff + 4'h1 == nbits)
                        nxt_state = UARX_STOP;
                  end
                  else
                     nxt_state = UARX_IDLE;
               end
            end
            default: nxt_state = UARX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_ff <= UARX_IDLE;
         phase_ff <= STATE_ZERO;
         ones_ff  <= 2'h0;
         nbit_ff  <= 4'h0;
         data_ff  <= DATA_ZERO;
         prev_ff  <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         ones_ff  <= nxt_ones;
         nbit_ff  <= nxt_nbit;
         data_ff  <= nxt_data;
         if (tick)
            prev_ff <= line;
      end
   end

   // ==========================================================
   // frame output; stop count select deliberately not used
   wire stop_done = tick && (state_ff == UARX_STOP) && (cur == md_c);
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         frame_ff <= '0;
         valid_ff <= 1'b0;
      end
      else
      begin
         valid_ff <= stop_done;
         if (stop_done)
         begin
            frame_ff.data             <= data_ff;
            frame_ff.frame_error_flag <= !vote_win;
         end
      end
   end

   assign o_frame       = frame_ff;
   assign o_frame_valid = valid_ff;
   assign o_busy        = (state_ff != UARX_IDLE);

   // ==========================================================
   // checks
   start_first_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (tick && state_ff == UARX_IDLE && fall) |=> (state_ff == UARX_START && phase_ff == STATE_ONE))
      else $error("start not entered on falling edge");
   reject_noise_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (tick && state_ff == UARX_START && cur == st_c && vote_win) |=> state_ff == UARX_IDLE)
      else $error("noisy start not rejected");
   start_accept_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (tick && state_ff == UARX_START && cur == st_c && !vote_win) |=> (state_ff == UARX_DATA && nbit_ff == 4'h0))
      else $error("valid start not accepted");
   frame_error_a: assert property (@(posedge i_clock) disable iff (i_rst)
      stop_done |=> (o_frame_valid && o_frame.frame_error_flag == !$past(vote_win)))
      else $error("frame error mismatch");
   early_start_a: assert property (@(posedge i_clock) disable iff (i_rst)
      stop_done |=> state_ff == UARX_IDLE)
      else $error("not ready after stop vote");
   bit_count_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_ff == UARX_DATA) |-> (nbit_ff < nbits))
      else $error("too many bits");
   valid_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_frame_valid |=> !o_frame_valid)
      else $error("valid longer than one cycle");
   phase_range_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_ff == UARX_START) |-> (phase_ff <= st_c))
      else $error("start phase out of range");
   // ticks since the last vote; a short bit period drifts off centre over a frame
   logic [3:0]  vote_gap_ff;
   wire         vote_tick = tick && (state_ff != UARX_IDLE) && (cur == md_c);
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         vote_gap_ff <= STATE_ZERO;
      else if (vote_tick)
         vote_gap_ff <= STATE_ZERO;
      else if (tick)
         vote_gap_ff <= vote_gap_ff + 4'h1;
   end
   bit_period_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (vote_tick && state_ff != UARX_START) |-> (vote_gap_ff == last_st))
      else $error("bit period is not one full bit");
   c_frame: cover property (@(posedge i_clock) o_frame_valid && !o_frame.frame_error_flag);
   c_ferr: cover property (@(posedge i_clock) o_frame_valid && o_frame.frame_error_flag);
   c_noise: cover property (@(posedge i_clock) tick && state_ff == UARX_START && cur == st_c && vote_win);
   c_dbl: cover property (@(posedge i_clock) o_frame_valid && dbl);
endmodule // uarx_rx_recovery

// ==== pkg/uarx_pkg.sv ====
/*
 * uarx_pkg: constants and carrier types for the asynchronous receive front end.
 * assumes a single 50 MHz system clock domain.
 */
package uarx_pkg;
   // ==========================================================
   // widths and timing
   localparam int          DIV_W          = 12;
   localparam int          CNT_W          = 4;
   localparam int          BITS_W         = 4;
   localparam logic [3:0]  MAX_BITS       = 4'ha;  // data + parity, upper limit
   localparam logic [3:0]  MIN_BITS       = 4'h5;  // data + parity, lower limit
   // last state of a bit: 15 normal, 7 double speed
   localparam logic [3:0]  LAST_NORM      = 4'hf;
   localparam logic [3:0]  LAST_DBL       = 4'h7;
   // start qualification samples, counted from the first low sample as 1
   localparam logic [3:0]  START_A_NORM   = 4'h8;
   localparam logic [3:0]  START_C_NORM   = 4'ha;
   localparam logic [3:0]  START_A_DBL    = 4'h4;
   localparam logic [3:0]  START_C_DBL    = 4'h6;
   // centre samples of a data bit, states numbered 1..16 / 1..8
   localparam logic [3:0]  MID_A_NORM     = 4'h8;
   localparam logic [3:0]  MID_C_NORM     = 4'ha;
   localparam logic [3:0]  MID_A_DBL      = 4'h4;
   localparam logic [3:0]  MID_C_DBL      = 4'h6;
   localparam logic [3:0]  STATE_ONE      = 4'h1;
   localparam logic [3:0]  STATE_ZERO     = 4'h0;
   localparam logic [9:0]  DATA_ZERO      = 10'h000;
   localparam logic [DIV_W-1:0] DIV_ZERO  = 12'h000;
   localparam logic [1:0]  SYNC_IDLE      = 2'h3;

   typedef enum logic [1:0] {
      UARX_IDLE  = 2'b00,
      UARX_START = 2'b01,
      UARX_DATA  = 2'b10,
      UARX_STOP  = 2'b11
   } uarx_state_e;

   typedef struct packed {
      logic [9:0] data;          // bits in arrival order, bit 0 first
      logic       frame_error_flag;
   } uarx_frame_s;

   typedef struct packed {
      logic             double_speed_select;
      logic             stop_bit_count_select;
      logic [3:0]       frame_bits;
      logic [DIV_W-1:0] baud_divisor;
   } uarx_cfg_s;
endpackage

// ==== core/uarx_tick_gen.sv ====
/*
 * uarx_tick_gen: one-cycle oversample strobe from the baud divisor.
 * assumes the divisor is held stable while frames are received.
 */
`timescale 1ns/1ps
module uarx_tick_gen
   import uarx_pkg::*;
(
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_rst,
   // divisor
   input  wire logic [DIV_W-1:0] i_baud_divisor,
   // strobe
   output logic                  o_tick
);
   logic [DIV_W-1:0] count_ff;
   logic [DIV_W-1:0] nxt_count;
   wire              wrap = (count_ff == DIV_ZERO);

   // period is divisor + 1 clocks
   assign nxt_count = wrap ? i_baud_divisor : count_ff - 12'h001;
   assign o_tick    = wrap;

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         count_ff <= DIV_ZERO;
      else
         count_ff <= nxt_count;
   end
endmodule // uarx_tick_gen

// ==== verif/uarx_tx_model.sv ====
/*
 * uarx_tx_model: behavioural remote transmitter driving the receive line.
 * assumes the bench clock; line idles high as with a pull-up.
 */
`timescale 1ns/1ps
module uarx_tx_model
(
   // clock
   input  wire logic i_clock,
   // serial line
   output logic      o_line
);
   initial o_line = 1'b1;
   // ==========================================================
   // frame: start, bits lsb first, one stop of stop_len clocks
   // exact bit rate, so the whole mismatch budget is left to the receiver
   task automatic send(input logic [9:0] d, input int n, input int cpb,
                       input logic stop, input int stop_len);
      @(posedge i_clock) o_line <= 1'b0;
      repeat (cpb - 1) @(posedge i_clock);
      for (int i = 0; i < n; i++)
      begin
         @(posedge i_clock) o_line <= d[i];
         repeat (cpb - 1) @(posedge i_clock);
      end
      @(posedge i_clock) o_line <= stop;
      repeat (stop_len - 1) @(posedge i_clock);
   endtask
   // ==========================================================
   // low pulse of len clocks, then idle for gap clocks
   task automatic pulse(input int len, input int gap);
      @(posedge i_clock) o_line <= 1'b0;
      repeat (len - 1) @(posedge i_clock);
      @(posedge i_clock) o_line <= 1'b1;
      repeat (gap) @(posedge i_clock);
   endtask
endmodule // uarx_tx_model

// ==== verif/uarx_rx_recovery_tb_top.sv ====
/*
 * uarx_rx_recovery_tb_top: random and corner frames against the receiver.
 * assumes uarx_pkg and the transmitter model are compiled first.
 */
`timescale 1ns/1ps
module uarx_rx_recovery_tb_top;
   import uarx_pkg::*;
   logic        i_clock;
   logic        i_rst;
   logic        rx_line;
   uarx_cfg_s   cfg;
   uarx_frame_s frame;
   logic        frame_valid;
   logic        busy;
   int          fails = 0;
   int          cmp_count = 0;

   uarx_tx_model u_tx (.i_clock(i_clock), .o_line(rx_line));
   uarx_rx_recovery u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_rx_line(rx_line),
      .i_cfg(cfg), .o_frame(frame), .o_frame_valid(frame_valid), .o_busy(busy));

   initial
   begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // ==========================================================
   // helpers
   function automatic int cpb();
      return (int'(cfg.baud_divisor) + 1) * (cfg.double_speed_select ? 8 : 16);
   endfunction
   function automatic logic [9:0] exp_data(input logic [9:0] d, input int n);
      return d & ((10'h1 << n) - 10'h1);
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic set_cfg(input logic dbl, input logic sbs, input int n, input int div);
      @(posedge i_clock) cfg <= '{dbl, sbs, 4'(n), 12'(div)};
      repeat (4) @(posedge i_clock);
   endtask
   task automatic wait_frame(input logic [9:0] d, input int n, input logic fe);
      for (int t = 0; t < 4000; t++)
      begin
         @(posedge i_clock);
         #1;
         if (frame_valid === 1'b1)
            break;
      end
      check("frame_valid", 16'(frame_valid), 16'h1);
      check("data", 16'(frame.data), 16'(exp_data(d, n)));
      check("frame_error", 16'(frame.frame_error_flag), 16'(fe));
      check("busy", 16'(busy), 16'h0);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // hang guard, well above the expected run length
   initial
   begin
      #1500000;
      fails++;
      tally_and_finish();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      logic [9:0] d;
      logic [9:0] d2;
      logic       stp;
      int         n;
      int         seen;
      i_rst = 1'b1;
      cfg = '{1'b0, 1'b0, 4'h8, 12'h001};
      void'($urandom(19227));
      repeat (12) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clock);
      // every length in both speeds, random divisor
      for (int k = 0; k < 24; k++)
      begin
         d = 10'($urandom);
         n = 5 + k % 6;
         set_cfg(1'((k / 6) % 2), 1'b0, n, int'($urandom_range(3, 1)));
         fork
            u_tx.send(d, n, cpb(), 1'b1, cpb());
            wait_frame(d, n, 1'b0);
         join
      end
      $display("test random_frames done");
      // low and high stop bit, stop count setting must not matter
      for (int j = 0; j < 4; j++)
      begin
         d = 10'($urandom);
         // stop level and stop count setting vary independently
         stp = 1'(j ^ (j / 2));
         set_cfg(1'(j), 1'(j / 2), 8, 1);
         fork
            u_tx.send(d, 8, cpb(), stp, cpb());
            wait_frame(d, 8, !stp);
         join
         u_tx.pulse(1, 2 * cpb());
      end
      $display("test frame_error done");
      // short low spike is noise in both speeds
      for (int j = 0; j < 2; j++)
      begin
         set_cfg(1'(j), 1'b0, 8, 2);
         seen = 0;
         fork
            u_tx.pulse(3 * 3, 20 * cpb());
            repeat (20 * cpb())
            begin
               @(posedge i_clock);
               #1;
               if (frame_valid === 1'b1)
                  seen++;
            end
         join
         check("spurious_frames", 16'(seen), 16'h0);
         check("busy_after_noise", 16'(busy), 16'h0);
      end
      $display("test noise_reject done");
      // next start right after the stop vote
      for (int j = 0; j < 2; j++)
      begin
         d = 10'($urandom);
         d2 = 10'($urandom);
         set_cfg(1'(j), 1'b0, 10, 1);
         fork
            begin
               u_tx.send(d, 10, cpb(), 1'b1, cpb() * 3 / 4);
               u_tx.send(d2, 10, cpb(), 1'b1, cpb());
            end
            begin
               wait_frame(d, 10, 1'b0);
               wait_frame(d2, 10, 1'b0);
            end
         join
      end
      $display("test back_to_back done");
      tally_and_finish();
   end
endmodule // uarx_rx_recovery_tb_top
